// file: pkg/qrs_params.svh
// Purpose: Shared constants for the quad rate memory port pair
// Assumes: Wide part only (four byte lanes, 36-bit data)
// Notes: Included by the package, the interface and both ends
`ifndef QRS_PARAMS_SVH
`define QRS_PARAMS_SVH

`define QRS_DATA_W 36
`define QRS_ADDR_W 18
`define QRS_BWS_W 4
`define QRS_LANE_W 9
`define QRS_HALF_DEPTH 262144
`define QRS_BURST_LEN 2

`endif

// file: pkg/qrs_pkg.sv
// Purpose: Types used by the device end of the memory port and by the bench
// Assumes: Constants come from qrs_params.svh
// Notes: Nothing here is imported; users write qrs_pkg::name
`include "qrs_params.svh"

package qrs_pkg;

    typedef logic [`QRS_DATA_W-1:0] qrs_data_t;
    typedef logic [`QRS_ADDR_W-1:0] qrs_addr_t;
    typedef logic [`QRS_BWS_W-1:0] qrs_bws_t;

    typedef enum logic [1:0] {
        QRS_RD_OFF,
        QRS_RD_BEAT0,
        QRS_RD_BEAT1
    } qrs_rd_state_t;

    typedef enum logic {
        QRS_WR_IDLE,
        QRS_WR_WAIT_KN
    } qrs_wr_state_t;

endpackage

// file: pkg/qrs_link_if.sv
// Purpose: Pin bundle between the memory device end and its controller
// Assumes: Clock pairs are levels sampled on ref_clk
// Notes: Read data drive is resolved by the bench from rdata_oe
`timescale 1ns/1ns
`include "qrs_params.svh"

interface qrs_link_if;
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic single_clk_mode;
    logic write_port_select_n;
    logic read_port_select_n;
    logic [`QRS_BWS_W-1:0] byte_write_select_n;
    logic [`QRS_ADDR_W-1:0] addr;
    logic [`QRS_DATA_W-1:0] wdata;
    logic [`QRS_DATA_W-1:0] rdata;
    logic rdata_oe;

    modport dev (
        input k,
        input k_n,
        input c,
        input c_n,
        input single_clk_mode,
        input write_port_select_n,
        input read_port_select_n,
        input byte_write_select_n,
        input addr,
        input wdata,
        output rdata,
        output rdata_oe
    );

    modport ctrl (
        output k,
        output k_n,
        output c,
        output c_n,
        output single_clk_mode,
        output write_port_select_n,
        output read_port_select_n,
        output byte_write_select_n,
        output addr,
        output wdata,
        input rdata,
        input rdata_oe
    );
endinterface

// file: verilog/qrs_device.sv
// Purpose: Port logic of a separate-I/O quad rate static memory, burst of two
// Assumes: All link pins are levels synchronous to ref_clk
// Notes: Array kept as two halves, one per beat of a burst
//
// What this block does
// - Write data taken on both input clock rises
// - Low write select at K starts write
// - High write select: data ignored, no write
// - Low byte selects store bytes, others kept
// - Each byte select governs one nine-bit lane
// - Byte selects sampled with their own data beat
// - Read address at K, write address at K_n
// - Two halves, 18-bit address reaches whole array
// - Address ignored for a deselected port
// - Read data on output clocks, or input clocks
// - Deselected read port floats outputs automatically
// - Low read select at K starts read
// - Deselect finishes burst, floats after next C
// - Each read returns two sequential beats
// - Controller supplies output clock pair for deskew
// - Accesses begin at K; single mode times output
`timescale 1ns/1ns
`include "qrs_params.svh"

module qrs_device (
    input wire logic ref_clk,
    input wire logic sys_rst,
    qrs_link_if.dev link
);

    // Array halves: beat 0 and beat 1 of each burst
    logic [`QRS_DATA_W-1:0] mem_lo [0:`QRS_HALF_DEPTH-1];
    logic [`QRS_DATA_W-1:0] mem_hi [0:`QRS_HALF_DEPTH-1];

    logic k_q_r;
    logic kn_q_r;
    logic c_q_r;
    logic cn_q_r;
    logic k_rise;
    logic kn_rise;
    logic out_rise0;
    logic out_rise1;

    qrs_pkg::qrs_wr_state_t wr_state_r;
    qrs_pkg::qrs_data_t wr_beat0_r;
    qrs_pkg::qrs_bws_t wr_bws0_r;

    logic rd_pend_r;
    qrs_pkg::qrs_addr_t rd_pend_addr_r;
    qrs_pkg::qrs_addr_t rd_burst_addr_r;
    qrs_pkg::qrs_rd_state_t rd_state_r;
    qrs_pkg::qrs_data_t rdata_r;
    logic rdata_oe_r;

    // Merge one beat into an old word lane by lane
    function automatic qrs_pkg::qrs_data_t lane_merge(
        input qrs_pkg::qrs_data_t old_word,
        input qrs_pkg::qrs_data_t new_word,
        input qrs_pkg::qrs_bws_t sel_n
    );
        qrs_pkg::qrs_data_t res;
        res = old_word;
        for (int i = 0; i < `QRS_BWS_W; i++) begin
            if (!sel_n[i]) begin
                res[i*`QRS_LANE_W +: `QRS_LANE_W] = new_word[i*`QRS_LANE_W +: `QRS_LANE_W];
            end
        end
        return res;
    endfunction

    // Rising edge of a clock pin seen as a level on ref_clk
    function automatic logic rising(
        input logic now_lvl,
        input logic prev_lvl
    );
        return now_lvl & ~prev_lvl;
    endfunction

    // Edge history of the clock pins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            k_q_r <= 1'b0;
            kn_q_r <= 1'b0;
            c_q_r <= 1'b0;
            cn_q_r <= 1'b0;
        end else begin
            k_q_r <= link.k;
            kn_q_r <= link.k_n;
            c_q_r <= link.c;
            cn_q_r <= link.c_n;
        end
    end

    assign k_rise = rising(link.k, k_q_r);
    assign kn_rise = rising(link.k_n, kn_q_r);

    // Output timing edges: C pair, or K pair in single clock mode
    always_comb begin
        if (link.single_clk_mode) begin
            out_rise0 = k_rise;
            out_rise1 = kn_rise;
        end else begin
            out_rise0 = rising(link.c, c_q_r);
            out_rise1 = rising(link.c_n, cn_q_r);
        end
    end

    // Write port sequencing
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_state_r <= qrs_pkg::QRS_WR_IDLE;
        end else begin
            case (wr_state_r)
                qrs_pkg::QRS_WR_IDLE: begin
                    if (k_rise && !link.write_port_select_n) begin
                        wr_state_r <= qrs_pkg::QRS_WR_WAIT_KN;
                    end
                end
                qrs_pkg::QRS_WR_WAIT_KN: begin
                    if (kn_rise) begin
                        wr_state_r <= qrs_pkg::QRS_WR_IDLE;
                    end
                end
                default: begin
                    wr_state_r <= qrs_pkg::QRS_WR_IDLE;
                end
            endcase
        end
    end

    // First beat and its byte selects, taken at K
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_beat0_r <= '0;
            wr_bws0_r <= '1;
        end else if (k_rise && !link.write_port_select_n) begin
            wr_beat0_r <= link.wdata;
            wr_bws0_r <= link.byte_write_select_n;
        end
    end

    // Both beats land at K_n with the write address; deselect leaves array alone
    always_ff @(posedge ref_clk) begin
        if (wr_state_r == qrs_pkg::QRS_WR_WAIT_KN && kn_rise) begin
            mem_lo[link.addr] <= lane_merge(mem_lo[link.addr], wr_beat0_r, wr_bws0_r);
            mem_hi[link.addr] <= lane_merge(mem_hi[link.addr], link.wdata,
                link.byte_write_select_n);
        end
    end
    // Writes only come from the state above, so a high select writes nothing

    // Read request capture at K, independent of the write port
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_pend_r <= 1'b0;
        end else if (k_rise && !link.read_port_select_n) begin
            rd_pend_r <= 1'b1;
        end else if (out_rise0) begin
            rd_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_pend_addr_r <= '0;
        end else if (k_rise && !link.read_port_select_n) begin
            rd_pend_addr_r <= link.addr;
        end
    end
    // Address held only when the port is selected: and reads run beside writes

    // Read burst state and output drive
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_state_r <= qrs_pkg::QRS_RD_OFF;
            rd_burst_addr_r <= '0;
            rdata_r <= '0;
            rdata_oe_r <= 1'b0;
        end else begin
            case (rd_state_r)
                qrs_pkg::QRS_RD_OFF,
                qrs_pkg::QRS_RD_BEAT1: begin
                    if (out_rise0) begin
                        if (rd_pend_r) begin
                            rd_state_r <= qrs_pkg::QRS_RD_BEAT0;
                            rd_burst_addr_r <= rd_pend_addr_r;
                            rdata_r <= mem_lo[rd_pend_addr_r];
                            rdata_oe_r <= 1'b1;
                        end else begin
                            rd_state_r <= qrs_pkg::QRS_RD_OFF;
                            rdata_oe_r <= 1'b0;
                        end
                    end
                end
                qrs_pkg::QRS_RD_BEAT0: begin
                    if (out_rise1) begin
                        rd_state_r <= qrs_pkg::QRS_RD_BEAT1;
                        rdata_r <= mem_hi[rd_burst_addr_r];
                    end
                end
                default: begin
                    rd_state_r <= qrs_pkg::QRS_RD_OFF;
                    rdata_oe_r <= 1'b0;
                end
            endcase
        end
    end

    assign link.rdata = rdata_r;
    assign link.rdata_oe = rdata_oe_r;

endmodule

// file: verilog/qrs_ctrl.sv
// Purpose: Controller end that drives the memory port pins
// Assumes: One request slot per K period, taken when the K phase is due
// Notes: Output clocks mirror the input clocks
`timescale 1ns/1ns
`include "qrs_params.svh"

module qrs_ctrl (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic single_mode,
    input wire logic wr_req,
    input wire logic [`QRS_ADDR_W-1:0] wr_addr,
    input wire logic [`QRS_DATA_W-1:0] wr_data0,
    input wire logic [`QRS_DATA_W-1:0] wr_data1,
    input wire logic [`QRS_BWS_W-1:0] wr_bws0_n,
    input wire logic [`QRS_BWS_W-1:0] wr_bws1_n,
    input wire logic rd_req,
    input wire logic [`QRS_ADDR_W-1:0] rd_addr,
    output logic req_taken,
    output logic rd_valid,
    output logic [2*`QRS_DATA_W-1:0] rd_data,
    qrs_link_if.ctrl link
);

    logic phase_r;
    logic k_r;
    logic kn_r;
    logic mode_r;
    logic wps_n_r;
    logic rps_n_r;
    logic [`QRS_BWS_W-1:0] bws_n_r;
    logic [`QRS_ADDR_W-1:0] addr_r;
    logic [`QRS_DATA_W-1:0] wdata_r;
    logic wr_hold_r;
    logic [`QRS_ADDR_W-1:0] wr_addr_hold_r;
    logic [`QRS_DATA_W-1:0] wr_d1_hold_r;
    logic [`QRS_BWS_W-1:0] wr_bws1_hold_r;
    logic req_taken_r;
    logic got_beat0_r;
    logic [`QRS_DATA_W-1:0] beat0_r;
    logic rd_valid_r;
    logic [2*`QRS_DATA_W-1:0] rd_data_r;

    // Divider: K high one cycle, K_n high the next
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_r <= 1'b0;
            k_r <= 1'b0;
            kn_r <= 1'b0;
            mode_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
            k_r <= ~phase_r;
            kn_r <= phase_r;
            mode_r <= single_mode;
        end
    end

    // Pin drive: K half carries read address and beat 0, K_n half write address and beat 1
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wps_n_r <= 1'b1;
            rps_n_r <= 1'b1;
            bws_n_r <= '1;
            addr_r <= '0;
            wdata_r <= '0;
            wr_hold_r <= 1'b0;
            wr_addr_hold_r <= '0;
            wr_d1_hold_r <= '0;
            wr_bws1_hold_r <= '1;
            req_taken_r <= 1'b0;
        end else if (!phase_r) begin
            wps_n_r <= ~wr_req;
            rps_n_r <= ~rd_req;
            addr_r <= rd_addr;
            wdata_r <= wr_data0;
            bws_n_r <= wr_req ? wr_bws0_n : '1;
            wr_hold_r <= wr_req;
            wr_addr_hold_r <= wr_addr;
            wr_d1_hold_r <= wr_data1;
            wr_bws1_hold_r <= wr_bws1_n;
            req_taken_r <= wr_req | rd_req;
        end else begin
            wps_n_r <= 1'b1;
            rps_n_r <= 1'b1;
            addr_r <= wr_addr_hold_r;
            wdata_r <= wr_d1_hold_r;
            bws_n_r <= wr_hold_r ? wr_bws1_hold_r : '1;
            req_taken_r <= 1'b0;
        end
    end

    // Read return: beat 0 in a K_n cycle, beat 1 in the next K cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            got_beat0_r <= 1'b0;
            beat0_r <= '0;
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
        end else begin
            rd_valid_r <= 1'b0;
            if (kn_r && link.rdata_oe) begin
                got_beat0_r <= 1'b1;
                beat0_r <= link.rdata;
            end else if (k_r && got_beat0_r) begin
                got_beat0_r <= 1'b0;
                rd_valid_r <= 1'b1;
                rd_data_r <= {link.rdata, beat0_r};
            end
        end
    end

    assign link.k = k_r;
    assign link.k_n = kn_r;
    assign link.c = k_r;
    assign link.c_n = kn_r;
    assign link.single_clk_mode = mode_r;
    assign link.write_port_select_n = wps_n_r;
    assign link.read_port_select_n = rps_n_r;
    assign link.byte_write_select_n = bws_n_r;
    assign link.addr = addr_r;
    assign link.wdata = wdata_r;
    assign req_taken = req_taken_r;
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;

endmodule

// file: testbench/qrs_checker.sv
// Purpose: Concurrent checks on the link between controller and device
// Assumes: All link pins are levels sampled on ref_clk
// Notes: Instantiated beside the link interface in tb_top
`timescale 1ns/1ns

module qrs_checker (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic c_n,
    input wire logic write_port_select_n,
    input wire logic read_port_select_n,
    input wire logic rdata_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    logic rd_cap;
    assign rd_cap = k && !read_port_select_n;

    a_k_toggle: assert property (1'b1 |=> $changed(k))
        else $error("input clock did not toggle");
    a_kn_opposite: assert property (k |-> !k_n ##1 k_n)
        else $error("negative input clock out of phase");
    a_out_clk_mirror: assert property (c == k && c_n == k_n)
        else $error("output clock pair differs from input pair");
    a_wsel_on_k: assert property (!write_port_select_n |-> k)
        else $error("write select low outside positive clock phase");
    a_rsel_on_k: assert property (!read_port_select_n |-> k)
        else $error("read select low outside positive clock phase");
    a_read_drives: assert property (rd_cap |-> ##3 rdata_oe ##1 rdata_oe)
        else $error("read burst not driven two beats");
    a_oe_has_cause: assert property (rdata_oe |-> $past(rd_cap, 3) || $past(rd_cap, 4))
        else $error("read data driven without a read");
    a_oe_pair: assert property ($rose(rdata_oe) |=> rdata_oe)
        else $error("read drive shorter than two beats");

    c_read: cover property (rd_cap);
    c_write: cover property (k && !write_port_select_n);
    c_both: cover property (rd_cap && !write_port_select_n);
endmodule

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for controller and device joined by the link
// Assumes: Requests are driven 1 ns after the rising clock edge
// Notes: Reference memory kept per half, merged per lane
`timescale 1ns/1ns
`include "qrs_params.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic single_mode = 1'b0;
    logic wr_req = 1'b0;
    logic rd_req = 1'b0;
    qrs_pkg::qrs_addr_t wr_addr = '0;
    qrs_pkg::qrs_addr_t rd_addr = '0;
    qrs_pkg::qrs_data_t wr_data0 = '0;
    qrs_pkg::qrs_data_t wr_data1 = '0;
    qrs_pkg::qrs_bws_t wr_bws0_n = 4'hf;
    qrs_pkg::qrs_bws_t wr_bws1_n = 4'hf;
    logic req_taken;
    logic rd_valid;
    logic [2*`QRS_DATA_W-1:0] rd_data;
    int n_mismatch = 0;
    int check_count = 0;
    qrs_pkg::qrs_data_t lo_m [int];
    qrs_pkg::qrs_data_t hi_m [int];

    qrs_link_if link();

    qrs_ctrl i_qrs_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .single_mode(single_mode),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_data0(wr_data0), .wr_data1(wr_data1),
        .wr_bws0_n(wr_bws0_n), .wr_bws1_n(wr_bws1_n), .rd_req(rd_req), .rd_addr(rd_addr),
        .req_taken(req_taken), .rd_valid(rd_valid), .rd_data(rd_data), .link(link));
    qrs_device i_qrs_device (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link));
    qrs_checker i_qrs_checker (.ref_clk(ref_clk), .sys_rst(sys_rst), .k(link.k),
        .k_n(link.k_n), .c(link.c), .c_n(link.c_n),
        .write_port_select_n(link.write_port_select_n),
        .read_port_select_n(link.read_port_select_n), .rdata_oe(link.rdata_oe));

    always #4 ref_clk = ~ref_clk;

    function automatic qrs_pkg::qrs_data_t merge(qrs_pkg::qrs_data_t od,
        qrs_pkg::qrs_data_t nw, qrs_pkg::qrs_bws_t sel_n);
        qrs_pkg::qrs_data_t r;
        r = od;
        for (int i = 0; i < `QRS_BWS_W; i++) begin
            if (!sel_n[i]) r[i*`QRS_LANE_W +: `QRS_LANE_W] = nw[i*`QRS_LANE_W +: `QRS_LANE_W];
        end
        return r;
    endfunction

    task automatic end_sim();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One request slot: optional write and optional read of the same address
    task automatic op(input logic w, input logic r, input qrs_pkg::qrs_addr_t a,
        input qrs_pkg::qrs_data_t d0, input qrs_pkg::qrs_data_t d1,
        input qrs_pkg::qrs_bws_t b0, input qrs_pkg::qrs_bws_t b1);
        qrs_pkg::qrs_data_t el;
        qrs_pkg::qrs_data_t eh;
        int i;
        wr_addr = a;
        rd_addr = a;
        wr_data0 = d0;
        wr_data1 = d1;
        wr_bws0_n = b0;
        wr_bws1_n = b1;
        wr_req = w;
        rd_req = r;
        for (i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            #1;
            if (req_taken === 1'b1) break;
        end
        `CHK("req_taken", 1'b1, req_taken)
        wr_req = 1'b0;
        rd_req = 1'b0;
        if (w) begin
            lo_m[a] = merge(lo_m.exists(a) ? lo_m[a] : '0, d0, b0);
            hi_m[a] = merge(hi_m.exists(a) ? hi_m[a] : '0, d1, b1);
        end
        // Write lands at the K_n rise, before the first read beat is fetched
        el = r ? lo_m[a] : '0;
        eh = r ? hi_m[a] : '0;
        @(posedge ref_clk);
        #1;
        if (r) begin
            for (i = 0; i < 10 && link.rdata_oe !== 1'b1; i++) begin
                @(posedge ref_clk);
                #1;
            end
            `CHK("rdata beat0", el, link.rdata)
            @(posedge ref_clk);
            #1;
            `CHK("rdata beat1", eh, link.rdata)
            @(posedge ref_clk);
            #1;
            `CHK("rdata_oe", 1'b0, link.rdata_oe)
            for (i = 0; i < 8 && rd_valid !== 1'b1; i++) begin
                @(posedge ref_clk);
                #1;
            end
            `CHK("rd_valid", 1'b1, rd_valid)
            `CHK("rd_data", {eh, el}, rd_data)
        end
    endtask

    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        @(posedge ref_clk);
        #1;
        op(1, 0, 18'h00005, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
        op(1, 0, 18'h3ffff, 36'h0a5a5a5a5, 36'h05a5a5a5a, 4'h0, 4'h0);
        op(0, 1, 18'h00005, 36'hbadbadbad, 36'hbadbadbad, 4'h0, 4'h0);
        op(0, 1, 18'h3ffff, 36'h0, 36'h0, 4'hf, 4'hf);
        op(1, 0, 18'h00005, 36'h111111111, 36'h222222222, 4'ha, 4'h5);
        op(0, 1, 18'h00005, 36'h0, 36'h0, 4'hf, 4'hf);
        op(1, 1, 18'h00005, 36'h333333333, 36'h444444444, 4'h0, 4'h0);
        single_mode = 1'b1;
        op(0, 1, 18'h00005, 36'h0, 36'h0, 4'hf, 4'hf);
        op(1, 1, 18'h3ffff, 36'h555555555, 36'h666666666, 4'h3, 4'hc);
        single_mode = 1'b0;
        op(0, 1, 18'h3ffff, 36'h0, 36'h0, 4'hf, 4'hf);
        end_sim();
    end
endmodule
